/* File: pkg/mbf_defines.vh */
`ifndef MBF_DEFINES_VH
`define MBF_DEFINES_VH
// register byte offsets
`define MBF_CTRL 8'h00
`define MBF_CARRIER 8'h04
`define MBF_HOP 8'h08
`define MBF_FSK_RATE 8'h0C
`define MBF_BURST_CNT 8'h10
`define MBF_BURST_RATE 8'h14
`define MBF_BURST_PHASE 8'h18
`define MBF_MOD_FREQ 8'h1C
`define MBF_STATUS 8'h20
`define MBF_DEVIATION 8'h24
`define MBF_PRESCALE 8'h28
`define MBF_POINTS 8'h2C
`define MBF_MEM_ADDR 8'h30
`define MBF_MEM_DATA 8'h34
`define MBF_WAVE_SAMPLE 8'h38
`define MBF_MOD_SAMPLE 8'h3C
// ctrl fields
`define MBF_C_FSK_EN 0
`define MBF_C_FSK_EXT 1
`define MBF_C_BURST_EN 2
`define MBF_C_BURST_GATED 3
`define MBF_C_TRIG_EXT 4
`define MBF_C_MOD_FM 5
`define MBF_C_MOD_EN 6
`define MBF_C_USER_SHAPE 7
// prescaler constants, points limits, sample clock
`define MBF_K_AM 32'd4900
`define MBF_K_FM 32'd624
`define MBF_PTS_MIN 12'd2000
`define MBF_PTS_MAX 12'd4000
`define MBF_C_AM_HZ 32'd5000000
`define MBF_C_FM_HZ 32'd1250000
`define MBF_CLK_HZ 32'd125000000
`define MBF_AM_DIV (`MBF_CLK_HZ / `MBF_C_AM_HZ)
`define MBF_FM_DIV (`MBF_CLK_HZ / `MBF_C_FM_HZ)
`define MBF_MHZ 32'd1000000
`define MBF_WAVE_LEN 32'd4096
`endif

/* File: rtl/mbf_modulation_burst_fsk_generator.v */
// Our own choices: the address map and register access over APB.
`include "mbf_defines.vh"
module mbf_modulation_burst_fsk_generator #(
	parameter PH_W = 32,
	parameter MEM_AW = 12
)
(
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire ext_trig_fsk,
	input wire burst_gate,
	output reg [PH_W-1:0] freq_word,
	output reg [11:0] wave_addr,
	output reg [7:0] am_sample,
	output reg [11:0] fm_sample,
	output reg mod_clk_en,
	output reg reload_busy,
	output reg dac_zero
);
	// software registers
	reg [7:0] ctrl_q;
	reg [31:0] carrier_q, hop_q, fsk_rate_q, burst_cnt_q, burst_rate_q, mod_freq_q;
	reg [11:0] phase_q; // start phase as memory index
	reg [11:0] mem_addr_q; // software write pointer
	reg [11:0] wave_sample_q; // main waveform sample at start phase
	// separate modulation memory and raw shape staging
	reg [11:0] mod_mem [0:(1<<MEM_AW)-1];
	reg [11:0] src_mem [0:(1<<MEM_AW)-1];
	// synchronisers
	reg trig_s1_q, trig_s2_q, trig_s3_q, gate_s1_q, gate_s2_q;
	// derived values
	reg [31:0] prescale_q, points_q;
	reg [31:0] deviation_q;
	// engines
	reg [31:0] fsk_cnt_q, burst_tmr_q, cyc_cnt_q, div_cnt_q, pre_cnt_q;
	reg fsk_lvl_q, bursting_q, int_trig_q;
	reg [11:0] rd_ptr_q;
	reg [1:0] st_q;
	reg [31:0] calc_cnt_q;
	reg [11:0] calc_idx_q;
	wire wr = psel & penable & pwrite;
	wire rd_acc = psel & penable & ~pwrite;
	wire fm = ctrl_q[`MBF_C_MOD_FM];
	wire fm_nx = (paddr == `MBF_CTRL) ? pwdata[`MBF_C_MOD_FM] : fm; // mode as it will be after this write
	localparam ST_IDLE = 2'd0;
	localparam ST_DIV = 2'd1;
	localparam ST_FILL = 2'd2;
	localparam ST_DONE = 2'd3;
	// minimum count for carrier band
	reg [31:0] min_cnt;
	always @*
	begin
		if (carrier_q <= `MBF_MHZ)
			min_cnt = 32'd1;
		else if (carrier_q <= 2*`MBF_MHZ)
			min_cnt = 32'd2;
		else if (carrier_q <= 3*`MBF_MHZ)
			min_cnt = 32'd3;
		else if (carrier_q <= 4*`MBF_MHZ)
			min_cnt = 32'd4;
		else
			min_cnt = 32'd5;
	end
	wire [31:0] eff_cnt = (burst_cnt_q < min_cnt) ? min_cnt : burst_cnt_q;
	// apb register writes
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_q <= 8'h00;
			carrier_q <= 32'h000F4240;
			hop_q <= 32'h000F4240;
			fsk_rate_q <= 32'h00000001;
			burst_cnt_q <= 32'h00000001;
			burst_rate_q <= 32'h00000001;
			phase_q <= 12'h000;
			mod_freq_q <= 32'h00000064;
			mem_addr_q <= 12'h000;
			wave_sample_q <= 12'h000;
		end
		else if (wr)
		begin
			case (paddr)
				`MBF_CTRL: ctrl_q <= pwdata[7:0];
				`MBF_CARRIER: carrier_q <= pwdata;
				`MBF_HOP: hop_q <= pwdata;
				`MBF_FSK_RATE: fsk_rate_q <= pwdata;
				`MBF_BURST_CNT: burst_cnt_q <= pwdata;
				`MBF_BURST_RATE: burst_rate_q <= pwdata;
				`MBF_BURST_PHASE: phase_q <= pwdata[11:0];
				`MBF_MOD_FREQ: mod_freq_q <= (pwdata == 32'h0) ? 32'h1 : pwdata;
				`MBF_MEM_ADDR: mem_addr_q <= pwdata[11:0];
				`MBF_MEM_DATA: mem_addr_q <= mem_addr_q + 12'h001;
				`MBF_WAVE_SAMPLE: wave_sample_q <= pwdata[11:0];
				default: ;
			endcase
		end
	end
	// raw shape staging, never the main waveform memory
	always @(posedge pclk)
	begin
		if (wr && paddr == `MBF_MEM_DATA)
			src_mem[mem_addr_q] <= pwdata[11:0];
	end
	// setting changes that force a new modulation table
	wire recalc = wr && (paddr == `MBF_CTRL || paddr == `MBF_MOD_FREQ || paddr == `MBF_CARRIER
		|| paddr == `MBF_BURST_CNT || paddr == `MBF_BURST_RATE || paddr == `MBF_BURST_PHASE);
	// apb read and answer: single-cycle access, zero wait states
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & (paddr > `MBF_MOD_SAMPLE || paddr[1:0] != 2'b00);
			if (psel && !penable && !pwrite)
			begin
				case (paddr)
					`MBF_CTRL: prdata <= {24'h0, ctrl_q};
					`MBF_CARRIER: prdata <= carrier_q;
					`MBF_HOP: prdata <= hop_q;
					`MBF_FSK_RATE: prdata <= fsk_rate_q;
					`MBF_BURST_CNT: prdata <= eff_cnt;
					`MBF_BURST_RATE: prdata <= burst_rate_q;
					`MBF_BURST_PHASE: prdata <= {20'h0, phase_q};
					`MBF_MOD_FREQ: prdata <= mod_freq_q;
					`MBF_STATUS: prdata <= {27'h0, gate_s2_q, trig_s2_q, bursting_q, fsk_lvl_q, reload_busy};
					`MBF_DEVIATION: prdata <= deviation_q;
					`MBF_PRESCALE: prdata <= prescale_q;
					`MBF_POINTS: prdata <= points_q;
					`MBF_MEM_ADDR: prdata <= {20'h0, mem_addr_q};
					`MBF_WAVE_SAMPLE: prdata <= {20'h0, wave_sample_q};
					`MBF_MOD_SAMPLE: prdata <= {20'h0, fm_sample};
					default: prdata <= 32'h0;
				endcase
			end
		end
	end
	// two-flop synchronisers, third flop for trigger edge
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			trig_s1_q <= 1'b0;
			trig_s2_q <= 1'b0;
			trig_s3_q <= 1'b0;
			gate_s1_q <= 1'b0;
			gate_s2_q <= 1'b0;
		end
		else
		begin
			trig_s1_q <= ext_trig_fsk;
			trig_s2_q <= trig_s1_q;
			trig_s3_q <= trig_s2_q;
			gate_s1_q <= burst_gate;
			gate_s2_q <= gate_s1_q;
		end
	end
	// table compute: prescaler by repeated subtraction, then points, then fill
	reg [31:0] k_rem, s_acc, two_c;
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_q <= ST_IDLE;
			k_rem <= 32'h0;
			s_acc <= 32'h0;
			two_c <= 32'h0;
			prescale_q <= 32'h1;
			points_q <= {20'h0, `MBF_PTS_MIN};
			calc_idx_q <= 12'h000;
			reload_busy <= 1'b0;
		end
		else if (recalc)
		begin
			// a write to ctrl, mod freq, carrier or a burst setting restarts the table, even mid-compute
			st_q <= ST_DIV;
			k_rem <= fm_nx ? `MBF_K_FM : `MBF_K_AM;
			s_acc <= 32'h0;
			reload_busy <= 1'b1;
		end
		else
		begin
			case (st_q)
				ST_IDLE:
					st_q <= ST_IDLE;
				ST_DIV:
				begin
					// truncating division k/f, one subtract per cycle
					if (k_rem >= mod_freq_q)
					begin
						k_rem <= k_rem - mod_freq_q;
						s_acc <= s_acc + 32'h1;
					end
					else
					begin
						prescale_q <= (s_acc == 32'h0) ? 32'h1 : s_acc;
						two_c <= 32'h0;
						k_rem <= 32'h0;
						st_q <= ST_FILL;
						calc_idx_q <= 12'h000;
					end
				end
				ST_FILL:
				begin
					// points: count how many (1+s)f fit in 2c
					if (k_rem + (prescale_q + 32'h1) * mod_freq_q <= 2 * (fm ? `MBF_C_FM_HZ : `MBF_C_AM_HZ))
					begin
						k_rem <= k_rem + (prescale_q + 32'h1) * mod_freq_q;
						two_c <= two_c + 32'h1;
					end
					else
					begin
						if (two_c > {20'h0, `MBF_PTS_MAX})
							points_q <= {20'h0, `MBF_PTS_MAX};
						else if (two_c < {20'h0, `MBF_PTS_MIN})
							points_q <= {20'h0, `MBF_PTS_MIN};
						else
							points_q <= {two_c[31:1], 1'b0};
						st_q <= ST_DONE;
					end
				end
				default:
				begin
					// resample into modulation memory, one point per cycle
					calc_idx_q <= calc_idx_q + 12'h001;
					if ({20'h0, calc_idx_q} + 32'h1 >= points_q)
					begin
						st_q <= ST_IDLE;
						reload_busy <= 1'b0;
					end
				end
			endcase
		end
	end
	// source position = idx * 4096 / points in 12.12 fixed point
	wire [47:0] pos = {12'h000, calc_idx_q, 24'h000000} / {16'h0000, ((points_q == 32'h0) ? 32'h1 : points_q)};
	wire [11:0] i0 = pos[23:12];
	wire [11:0] i1 = i0 + 12'h001;
	wire [11:0] fr = pos[11:0];
	wire [11:0] s0 = src_mem[i0];
	wire [11:0] s1 = src_mem[i1];
	wire [24:0] interp = {1'b0, s0, 12'h000} + ({13'h0, s1} - {13'h0, s0}) * {13'h0, fr};
	always @(posedge pclk)
	begin
		if (st_q == ST_DONE)
			mod_mem[calc_idx_q] <= ctrl_q[`MBF_C_USER_SHAPE] ? interp[23:12] : s0;
	end
	// point clock: base divider to max rate, then prescaler
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			div_cnt_q <= 32'h0;
			pre_cnt_q <= 32'h0;
			mod_clk_en <= 1'b0;
			rd_ptr_q <= 12'h000;
			am_sample <= 8'h00;
			fm_sample <= 12'h000;
		end
		else
		begin
			mod_clk_en <= 1'b0;
			if (div_cnt_q + 32'h1 >= (fm ? `MBF_FM_DIV : `MBF_AM_DIV))
			begin
				div_cnt_q <= 32'h0;
				if (pre_cnt_q >= prescale_q)
				begin
					pre_cnt_q <= 32'h0;
					mod_clk_en <= ctrl_q[`MBF_C_MOD_EN] & ~reload_busy & ~recalc;
					if (ctrl_q[`MBF_C_MOD_EN] && !reload_busy && !recalc)
					begin
						rd_ptr_q <= ({20'h0, rd_ptr_q} + 32'h1 >= points_q) ? 12'h000 : rd_ptr_q + 12'h001;
						am_sample <= mod_mem[rd_ptr_q][11:4];
						fm_sample <= mod_mem[rd_ptr_q];
					end
				end
				else
					pre_cnt_q <= pre_cnt_q + 32'h1;
			end
			else
				div_cnt_q <= div_cnt_q + 32'h1;
		end
	end
	// fsk square wave and frequency word
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fsk_cnt_q <= 32'h0;
			fsk_lvl_q <= 1'b0;
			freq_word <= {PH_W{1'b0}};
			deviation_q <= 32'h0;
		end
		else
		begin
			deviation_q <= hop_q - carrier_q;
			if (fsk_cnt_q + 32'h1 >= fsk_rate_q)
			begin
				fsk_cnt_q <= 32'h0;
				fsk_lvl_q <= ~fsk_lvl_q;
			end
			else
				fsk_cnt_q <= fsk_cnt_q + 32'h1;
			if (ctrl_q[`MBF_C_FSK_EN])
				freq_word <= ((ctrl_q[`MBF_C_FSK_EXT] ? trig_s2_q : fsk_lvl_q) ? hop_q : carrier_q);
			else
				freq_word <= carrier_q;
		end
	end
	// burst engine: cycles counted when the address returns to the start phase
	wire trig_ev = ctrl_q[`MBF_C_TRIG_EXT] ? (trig_s2_q & ~trig_s3_q) : int_trig_q;
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			burst_tmr_q <= 32'h0;
			int_trig_q <= 1'b0;
			bursting_q <= 1'b0;
			cyc_cnt_q <= 32'h0;
			wave_addr <= 12'h000;
			dac_zero <= 1'b0;
		end
		else
		begin
			int_trig_q <= 1'b0;
			if (burst_tmr_q + 32'h1 >= burst_rate_q)
			begin
				burst_tmr_q <= 32'h0;
				int_trig_q <= 1'b1;
			end
			else
				burst_tmr_q <= burst_tmr_q + 32'h1;
			// gate only masks the converter; offset path is elsewhere
			dac_zero <= ctrl_q[`MBF_C_BURST_EN] & ctrl_q[`MBF_C_BURST_GATED] & ~gate_s2_q;
			if (!ctrl_q[`MBF_C_BURST_EN] || ctrl_q[`MBF_C_BURST_GATED])
			begin
				bursting_q <= 1'b0;
				wave_addr <= wave_addr + 12'h001;
			end
			else if (!bursting_q)
			begin
				wave_addr <= phase_q;
				if (trig_ev)
				begin
					bursting_q <= 1'b1;
					cyc_cnt_q <= 32'h0;
					wave_addr <= phase_q + 12'h001;
				end
			end
			else
			begin
				wave_addr <= wave_addr + 12'h001;
				if (wave_addr + 12'h001 == phase_q)
				begin
					cyc_cnt_q <= cyc_cnt_q + 32'h1;
					if (cyc_cnt_q + 32'h1 >= eff_cnt)
					begin
						bursting_q <= 1'b0;
						wave_addr <= phase_q;
					end
				end
			end
		end
	end
endmodule

/* File: verification/mbf_assertions.sv */
module mbf_chk (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire burst_gate,
	input wire mod_clk_en,
	input wire reload_busy,
	input wire dac_zero
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// setup cycle of any transfer
	sequence s_setup;
		psel && !penable;
	endsequence
	// setup cycle aimed past the last register
	sequence s_bad_setup;
		psel && !penable && paddr > 8'h3C;
	endsequence
	// gate seen high long enough to clear the synchroniser
	sequence s_gate_high;
		burst_gate [*5];
	endsequence
	chk_setup_answer: assert property (s_setup |=> pready)
		else $error("no pready after setup");
	chk_pready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_pready_access: assert property (pready |-> psel && penable)
		else $error("pready outside access phase");
	chk_slverr_pair: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	chk_unmapped_err: assert property (s_bad_setup |=> pslverr)
		else $error("unmapped access not refused");
	chk_err_read_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read returned data");
	// point clock never faster than one pulse in nine cycles
	chk_point_spacing: assert property (mod_clk_en |=> !mod_clk_en [*8])
		else $error("point clock too fast");
	chk_busy_no_point: assert property (reload_busy |-> !mod_clk_en)
		else $error("point clock during recompute");
	chk_gate_run: assert property (s_gate_high |-> !dac_zero)
		else $error("converter zeroed while gate high");
endmodule

bind mbf_modulation_burst_fsk_generator mbf_chk u_mbf_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.burst_gate(burst_gate), .mod_clk_en(mod_clk_en), .reload_busy(reload_busy), .dac_zero(dac_zero));

/* File: verification/mbf_ext_src.sv */
module mbf_ext_src (
	input wire pclk,
	input wire fsk_req,
	input wire gate_req,
	input wire [1:0] lag,
	output logic ext_trig_fsk,
	output logic burst_gate
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] fsk_d = 4'h0; // delay line of the keying level
	logic [3:0] gate_d = 4'h0; // delay line of the gate level
	// lag lets the source answer late, so the synchroniser sees unaligned edges
	always @(posedge pclk)
	begin
		fsk_d <= {fsk_d[2:0], fsk_req};
		gate_d <= {gate_d[2:0], gate_req};
	end
	assign ext_trig_fsk = fsk_d[lag];
	assign burst_gate = gate_d[lag];
endmodule

/* File: verification/tb_modulation_burst_fsk_generator.sv */
`include "mbf_defines.vh"
module tb_modulation_burst_fsk_generator;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_trig_fsk, burst_gate;
	logic mod_clk_en, reload_busy, dac_zero, fsk_req, gate_req;
	logic [7:0] paddr, am_sample;
	logic [31:0] pwdata, prdata, freq_word, car, hop;
	logic [11:0] wave_addr, fm_sample;
	logic [1:0] lag;
	logic [63:0] sp;
	logic [31:0] v, prev_fw;
	logic [32:0] exp_q[$]; // notes of expected {pslverr, prdata}
	int fail_count = 0;
	int checks = 0;
	int n;
	int car_t[5] = '{1000000, 1000001, 2500000, 4000000, 5000000};
	int f_t[5] = '{1000, 5000, 100, 1, 10};
	logic fm_t[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};

	mbf_modulation_burst_fsk_generator u_mbf_modulation_burst_fsk_generator (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ext_trig_fsk(ext_trig_fsk), .burst_gate(burst_gate),
		.freq_word(freq_word), .wave_addr(wave_addr), .am_sample(am_sample), .fm_sample(fm_sample),
		.mod_clk_en(mod_clk_en), .reload_busy(reload_busy), .dac_zero(dac_zero));
	mbf_ext_src u_mbf_ext_src (.pclk(pclk), .fsk_req(fsk_req), .gate_req(gate_req), .lag(lag),
		.ext_trig_fsk(ext_trig_fsk), .burst_gate(burst_gate));

	// 125 mhz clock
	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	// compare and count
	task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] v);
		checks++;
		if (v !== e)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, e, v);
		end
	endtask

	// one apb transfer; a read leaves its expectation in the queue
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
		int k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		if (!wr)
			exp_q.push_back(e);
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && k < 50)
		begin
			@(posedge pclk);
			k++;
		end
		if (k == 50)
			chk("pready wait", 33'h0, 33'h1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0);
	endtask

	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		apb(1'b0, a, 32'h0, e);
	endtask

	// bounded wait for the table recompute to finish
	task automatic wait_idle;
		int k = 0;
		repeat (3) @(posedge pclk);
		while (reload_busy !== 1'b0 && k < 30000)
		begin
			@(posedge pclk);
			k++;
		end
		if (k == 30000)
			chk("recompute wait", 33'h0, 33'h1);
	endtask

	// expected {prescaler, points} worked out from the modulation equations
	function automatic logic [63:0] pts(input logic fm, input logic [31:0] fr);
		logic [31:0] s, p, c;
		s = (fm ? `MBF_K_FM : `MBF_K_AM) / fr;
		c = fm ? `MBF_C_FM_HZ : `MBF_C_AM_HZ;
		if (s < 1)
			s = 1;
		p = (2 * c) / ((1 + s) * fr);
		p[0] = 1'b0;
		if (p < 2000)
			p = 2000;
		if (p > 4000)
			p = 4000;
		return {s, p};
	endfunction

	task print_verdict;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// result watcher: each read answer takes the oldest note
	always @(posedge pclk)
	begin
		if (psel && penable && !pwrite && pready === 1'b1)
			chk("read data", exp_q.pop_front(), {pslverr, prdata});
	end

	// hang guard, well past the expected run length
	initial
	begin
		#800000;
		fail_count++;
		print_verdict();
	end

	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, fsk_req, gate_req, lag, presetn} = '0;
		void'($urandom(84));
		repeat (3) @(posedge pclk);
		chk("reset outputs", 33'h0, {32'h0, |{pready, pslverr, prdata, freq_word, wave_addr, am_sample, fm_sample,
			mod_clk_en, reload_busy, dac_zero}});
		presetn <= 1'b1;
		// external keying with random frequencies, both signs of deviation
		for (int i = 0; i < 4; i++)
		begin
			car = $urandom_range(900000, 1000);
			hop = $urandom_range(900000, 1000);
			lag <= i[1:0];
			wr(`MBF_CARRIER, car);
			wr(`MBF_HOP, hop);
			wr(`MBF_CTRL, 32'h3);
			rd(`MBF_DEVIATION, {1'b0, hop - car});
			fsk_req <= 1'b1;
			repeat (10) @(posedge pclk);
			chk("hop freq", {1'b0, hop}, {1'b0, freq_word});
			fsk_req <= 1'b0;
			repeat (10) @(posedge pclk);
			chk("carrier freq", {1'b0, car}, {1'b0, freq_word});
		end
		// internal keying: 20 cycle half period gives ten hops in 200 cycles
		wr(`MBF_FSK_RATE, 32'd20);
		wr(`MBF_CTRL, 32'h1);
		n = 0;
		prev_fw = freq_word;
		repeat (200)
		begin
			@(posedge pclk);
			n += (freq_word !== prev_fw);
			prev_fw = freq_word;
		end
		chk("internal hops", 33'h1, {32'h0, n >= 9 && n <= 11});
		// minimum burst count per carrier band
		for (int i = 0; i < 5; i++)
		begin
			wr(`MBF_CARRIER, car_t[i]);
			wr(`MBF_BURST_CNT, 32'h1);
			rd(`MBF_BURST_CNT, i + 1);
		end
		// prescaler and points for am and fm
		for (int i = 0; i < 5; i++)
		begin
			wr(`MBF_CTRL, fm_t[i] ? 32'h60 : 32'h40);
			wr(`MBF_MOD_FREQ, f_t[i]);
			wait_idle();
			sp = pts(fm_t[i], f_t[i]);
			rd(`MBF_PRESCALE, {1'b0, sp[63:32]});
			rd(`MBF_POINTS, {1'b0, sp[31:0]});
		end
		// one random level in every staging word, then an interpolated am table
		v = $urandom & 32'h00000FFF;
		wr(`MBF_MEM_ADDR, 32'h0);
		repeat (4096) wr(`MBF_MEM_DATA, v);
		rd(`MBF_MEM_ADDR, 33'h0);
		wr(`MBF_CTRL, 32'hC0);
		wr(`MBF_MOD_FREQ, 32'd1000);
		wait_idle();
		// second point clock pulse reads a freshly written entry
		repeat (2)
		begin
			@(posedge pclk);
			while (mod_clk_en !== 1'b1)
				@(posedge pclk);
		end
		chk("fm sample", {21'h0, v[11:0]}, {21'h0, fm_sample});
		chk("am sample", {25'h0, v[11:4]}, {25'h0, am_sample});
		rd(`MBF_MOD_SAMPLE, {21'h0, v[11:0]});
		// gated burst follows the gate level
		wr(`MBF_CTRL, 32'hC);
		repeat (10) @(posedge pclk);
		chk("gate low zero", 33'h1, {32'h0, dac_zero});
		gate_req <= 1'b1;
		repeat (10) @(posedge pclk);
		chk("gate high run", 33'h0, {32'h0, dac_zero});
		// externally triggered burst: one cycle asked, three forced at 3 mhz
		wr(`MBF_CARRIER, 32'd3000000);
		wr(`MBF_BURST_CNT, 32'd1);
		wr(`MBF_BURST_PHASE, 32'h10);
		wr(`MBF_CTRL, 32'h14);
		wait_idle();
		repeat (20) @(posedge pclk);
		chk("idle address", 33'h10, {21'h0, wave_addr});
		fsk_req <= 1'b1;
		repeat (4) @(posedge pclk);
		fsk_req <= 1'b0;
		n = 0;
		while (wave_addr === 12'h010 && n < 100)
		begin
			@(posedge pclk);
			n++;
		end
		chk("burst started", 33'h1, {32'h0, n < 100});
		// each complete cycle shows every address but the held phase point
		n = 1;
		repeat (12400)
		begin
			@(posedge pclk);
			n += (wave_addr !== 12'h010);
		end
		chk("burst length", {1'b0, 32'd3 * (`MBF_WAVE_LEN - 32'd1)}, n);
		chk("burst stopped", 33'h10, {21'h0, wave_addr});
		// refused accesses
		rd(8'h40, {1'b1, 32'h0});
		wr(8'h06, 32'h5);
		rd(`MBF_CARRIER, {1'b0, 32'd3000000});
		repeat (5) @(posedge pclk);
		chk("notes left", 33'h0, exp_q.size());
		print_verdict();
	end
endmodule
